// ### dcrc_pkg.sv
package dcrc_pkg;

	// -------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_REFI_NS = 7800;
	// A longest interval rounds down to whole cycles.
	localparam int SR_REFRESH_CYCLES = T_REFI_NS / CLK_PERIOD_NS;
	localparam logic [9:0] SR_CNT_LAST = 10'(SR_REFRESH_CYCLES - 1);

	// -------------------------------------------------------------------
	// Field positions, limits and reset values
	// -------------------------------------------------------------------
	localparam int AUTO_PRE_BIT = 10;
	localparam logic [2:0] AL_MAX = 3'h6;
	localparam int PIPE_DEPTH = 6;
	localparam logic [4:0] HALF_BL4 = 5'h02;
	localparam logic [4:0] HALF_BL8 = 5'h04;
	localparam logic [1:0] LAST_PAIR_BL4 = 2'h1;
	localparam logic [1:0] LAST_PAIR_BL8 = 2'h3;
	localparam logic [9:0] SR_CNT_RESET = 10'h000;
	localparam logic [4:0] AP_CNT_RESET = 5'h00;

	typedef enum logic [0:0] {
		DCRC_ST_NORMAL = 1'b0,
		DCRC_ST_SELF = 1'b1
	} dcrc_mode_t;

	// Command pins as seen at the device.
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] ba;
		logic [12:0] addr;
	} dcrc_pins_t;

	localparam dcrc_pins_t PINS_RESET = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
		2'h0, 13'h0000};

	// Column command on its way through the additive latency pipe.
	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] bank;
		logic [9:0] col;
	} dcrc_col_t;

	// One clock of burst: two columns, one per data edge.
	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] bank;
		logic [9:0] col_a;
		logic [9:0] col_b;
	} dcrc_beat_t;

	// Burst configuration from the mode registers.
	typedef struct packed {
		logic [2:0] al;
		logic [2:0] cl;
		logic [2:0] wr;
		logic bl8;
		logic interleave;
	} dcrc_cfg_t;

	typedef struct packed {
		logic open;
		logic [12:0] row;
		logic [4:0] ap_cnt;
	} dcrc_bank_t;

endpackage

// ### dcrc_bank.sv
`timescale 1ns/1ps
`default_nettype none
module dcrc_bank (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Events for this bank
	input wire logic i_act,
	input wire logic i_close,
	input wire logic i_ap_load,
	input wire logic [4:0] i_ap_cnt,
	input wire logic [12:0] i_row,
	// State
	output logic o_open,
	output logic [12:0] o_row
);
	import dcrc_pkg::*;

	dcrc_bank_t s;
	dcrc_bank_t next_s;

	always_comb
	begin
		next_s = s;
		if (i_act)
		begin
			next_s.open = 1'b1;
			next_s.row = i_row;
		end
		if (s.ap_cnt != AP_CNT_RESET)
		begin
			next_s.ap_cnt = s.ap_cnt - 5'h01;
			if (s.ap_cnt == 5'h01)
			begin
				next_s.open = 1'b0;
			end
		end
		// An explicit close also drops a pending auto precharge, so it
		// cannot later close a row that was opened again.
		if (i_close)
		begin
			next_s.open = 1'b0;
			next_s.ap_cnt = AP_CNT_RESET;
		end
		if (i_ap_load)
		begin
			next_s.ap_cnt = i_ap_cnt;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s <= '{1'b0, 13'h0000, AP_CNT_RESET};
		end
		else
		begin
			s <= next_s;
		end
	end

	assign o_open = s.open;
	assign o_row = s.row;

endmodule
`default_nettype wire

// ### dcrc_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcrc_top (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Command pins
	input wire dcrc_pkg::dcrc_pins_t i_pins,
	// Mode register settings
	input wire dcrc_pkg::dcrc_cfg_t i_cfg,
	// Bank state
	output logic [3:0] o_bank_open,
	output logic [3:0][12:0] o_bank_row,
	// Column traffic towards the array
	output dcrc_pkg::dcrc_beat_t o_beat,
	// Refresh and power state
	output logic o_self_refresh,
	output logic o_dll_on,
	output logic o_refresh
);
	import dcrc_pkg::*;

	typedef struct packed {
		dcrc_pins_t sync1;
		dcrc_pins_t sync2;
		logic cke_q;
		dcrc_mode_t mode;
		dcrc_col_t [PIPE_DEPTH-1:0] pipe;
		dcrc_col_t bst_cmd;
		logic [1:0] bst_pair;
		logic bst_active;
		dcrc_beat_t beat;
		logic [9:0] sr_cnt;
		logic refresh;
	} dcrc_state_t;

	dcrc_state_t s;
	dcrc_state_t next_s;
	dcrc_pins_t p;
	logic dec_en;
	logic cmd_act;
	logic cmd_col;
	logic cmd_pre;
	logic cmd_ref;
	logic sr_entry;
	logic [2:0] al;
	logic [4:0] half_bl;
	logic [4:0] ap_cnt;
	logic close_all;
	dcrc_col_t col_new;
	dcrc_col_t col_issue;

	assign p = s.sync2;

	function automatic logic [9:0] dcrc_wrap(input logic [9:0] start,
		input logic [2:0] idx, input logic bl8, input logic il);
		logic [2:0] low;
		if (il)
		begin
			low = start[2:0] ^ idx;
		end
		else
		begin
			low = {start[2] ^ idx[2], 2'(start[1:0] + idx[1:0])};
		end
		if (bl8)
		begin
			return {start[9:3], low};
		end
		return {start[9:2], low[1:0]};
	endfunction

	// -------------------------------------------------------------------
	// Command decode
	// -------------------------------------------------------------------
	always_comb
	begin
		dec_en = (s.mode == DCRC_ST_NORMAL) && !p.cs_n && p.cke && s.cke_q;
		cmd_act = dec_en && !p.ras_n && p.cas_n && p.we_n;
		cmd_col = dec_en && p.ras_n && !p.cas_n;
		cmd_pre = dec_en && !p.ras_n && p.cas_n && !p.we_n;
		cmd_ref = dec_en && !p.ras_n && !p.cas_n && p.we_n;
		sr_entry = (s.mode == DCRC_ST_NORMAL) && s.cke_q && !p.cke
			&& !p.cs_n && !p.ras_n && !p.cas_n && p.we_n;
		close_all = (cmd_pre && p.addr[AUTO_PRE_BIT]) || cmd_ref || sr_entry;
		al = (i_cfg.al > AL_MAX) ? AL_MAX : i_cfg.al;
		half_bl = i_cfg.bl8 ? HALF_BL8 : HALF_BL4;
		// Counter is loaded one edge after decode, hence the minus one.
		if (p.we_n)
		begin
			ap_cnt = 5'(al) + half_bl - 5'h01;
		end
		else
		begin
			// write: WL plus BL/2 plus recovery
			ap_cnt = 5'(al) + 5'(i_cfg.cl) - 5'h01 + half_bl
				+ 5'(i_cfg.wr) - 5'h01;
		end
		col_new = '{cmd_col, !p.we_n, p.ba, p.addr[9:0]};
	end

	// -------------------------------------------------------------------
	// Banks
	// -------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_bank
			dcrc_bank u_bank (
				.i_mclk(i_mclk),
				.i_rst(i_rst),
				.i_act(cmd_act && (p.ba == 2'(g))),
				.i_close(close_all
					|| (cmd_pre && (p.ba == 2'(g)))),
				.i_ap_load(cmd_col && p.addr[AUTO_PRE_BIT]
					&& (p.ba == 2'(g))),
				.i_ap_cnt(ap_cnt),
				.i_row(p.addr),
				.o_open(o_bank_open[g]),
				.o_row(o_bank_row[g])
			);
		end
	endgenerate

	// -------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.sync1 = i_pins;
		next_s.sync2 = s.sync1;
		next_s.cke_q = p.cke;
		next_s.refresh = cmd_ref;
		next_s.pipe[0] = col_new;
		for (int i = 1; i < PIPE_DEPTH; i++)
		begin
			next_s.pipe[i] = s.pipe[i-1];
		end
		col_issue = (al == 3'h0) ? col_new : s.pipe[al - 3'h1];
		// early commands rely on programmed latency
		if (col_issue.valid)
		begin
			// A new column command cuts the running burst short.
			next_s.bst_cmd = col_issue;
			next_s.bst_pair = 2'h0;
			next_s.bst_active = 1'b1;
		end
		else if (s.bst_active)
		begin
			if (s.bst_pair == (i_cfg.bl8 ? LAST_PAIR_BL8 : LAST_PAIR_BL4))
			begin
				next_s.bst_active = 1'b0;
			end
			else
			begin
				next_s.bst_pair = s.bst_pair + 2'h1;
			end
		end
		next_s.beat.valid = next_s.bst_active;
		next_s.beat.write = next_s.bst_cmd.write;
		next_s.beat.bank = next_s.bst_cmd.bank;
		next_s.beat.col_a = dcrc_wrap(next_s.bst_cmd.col,
			{next_s.bst_pair, 1'b0}, i_cfg.bl8, i_cfg.interleave);
		next_s.beat.col_b = dcrc_wrap(next_s.bst_cmd.col,
			{next_s.bst_pair, 1'b1}, i_cfg.bl8, i_cfg.interleave);
		// self refresh timer and exit
		// The timer runs on the input clock; the controller must keep it
		// running, since a real part would use its own oscillator here.
		case (s.mode)
			DCRC_ST_NORMAL:
			begin
				next_s.sr_cnt = SR_CNT_RESET;
				if (sr_entry)
				begin
					next_s.mode = DCRC_ST_SELF;
				end
			end
			DCRC_ST_SELF:
			begin
				next_s.sr_cnt = (s.sr_cnt == SR_CNT_LAST) ? SR_CNT_RESET
					: s.sr_cnt + 10'h001;
				next_s.refresh = (s.sr_cnt == SR_CNT_LAST);
				// exit relies on idle commands after
				if (p.cke)
				begin
					next_s.mode = DCRC_ST_NORMAL;
				end
			end
			default:
			begin
				next_s.mode = DCRC_ST_NORMAL;
			end
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s <= '{PINS_RESET, PINS_RESET, 1'b0, DCRC_ST_NORMAL, '0, '0,
				2'h0, 1'b0, '0, SR_CNT_RESET, 1'b0};
		end
		else
		begin
			s <= next_s;
		end
	end

	assign o_beat = s.beat;
	assign o_self_refresh = (s.mode == DCRC_ST_SELF);
	assign o_refresh = s.refresh;

	logic dll_on;
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			dll_on <= 1'b1;
		end
		else
		begin
			dll_on <= (next_s.mode == DCRC_ST_NORMAL);
		end
	end
	assign o_dll_on = dll_on;

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	// No command that could move a bank's state is being decoded.
	logic no_cmd;
	assign no_cmd = !(cmd_act || cmd_col || cmd_pre || cmd_ref || sr_entry);

	sequence rd_ap0_s;
		cmd_col && p.we_n && p.addr[AUTO_PRE_BIT] && p.ba == 2'h0
			&& o_bank_open[0] && i_cfg.al == 3'h0 && i_cfg.bl8;
	endsequence
	sequence wr_ap0_s;
		cmd_col && !p.we_n && p.addr[AUTO_PRE_BIT] && p.ba == 2'h0
			&& o_bank_open[0]
			&& i_cfg == dcrc_cfg_t'{3'h0, 3'h3, 3'h3, 1'b0, 1'b0};
	endsequence

	act_opens_a: assert property (cmd_act |=> o_bank_open[$past(p.ba)])
		else $error("activate did not open bank");
	al_delay_a: assert property (cmd_col && i_cfg.al == 3'h2
		&& $stable(i_cfg) |-> ##3 o_beat.valid)
		else $error("column command not delayed by latency");
	rd_map_a: assert property (cmd_col && i_cfg.al == 3'h0 |=>
		o_beat.bank == $past(p.ba) && o_beat.col_a[9:3] == $past(p.addr[9:3]))
		else $error("column command bank or column wrong");
	wr_flag_a: assert property (cmd_col && i_cfg.al == 3'h0 |=>
		o_beat.write == $past(!p.we_n))
		else $error("write flag wrong");
	rd_ap_a: assert property (rd_ap0_s ##1 no_cmd [*3] |->
		o_bank_open[0] ##1 !o_bank_open[0])
		else $error("read auto precharge timing wrong");
	wr_ap_a: assert property (wr_ap0_s ##1 no_cmd [*6] |->
		o_bank_open[0] ##1 !o_bank_open[0])
		else $error("write auto precharge timing wrong");
	pre_all_a: assert property (cmd_pre && p.addr[AUTO_PRE_BIT]
		|=> o_bank_open == 4'h0)
		else $error("precharge all left a bank open");
	sr_entry_a: assert property (sr_entry |=> o_self_refresh && !o_dll_on
		&& o_bank_open == 4'h0)
		else $error("self refresh entry wrong");
	ref_idle_a: assert property (cmd_ref |=> o_refresh
		&& o_bank_open == 4'h0)
		else $error("refresh left a bank open");
	desel_a: assert property (p.cs_n |-> !cmd_act && !cmd_col && !cmd_ref)
		else $error("deselected command decoded");
	wrap_a: assert property (o_beat.valid && i_cfg.bl8
		|-> o_beat.col_a[9:3] == o_beat.col_b[9:3])
		else $error("burst left its group");

endmodule
`default_nettype wire

// ### dcrc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcrc_ctrl_model #(
	parameter int T_XSNR = 20
) (
	// Clock
	input wire logic i_mclk,
	// Command pins towards the device
	output dcrc_pkg::dcrc_pins_t o_pins
);
	import dcrc_pkg::*;
	dcrc_pins_t req;
	dcrc_pins_t nx;
	logic pend = 1'b0;
	// termination never updated
	// No termination pin reaches the device and no resistance update is
	// ever sent, so the turn-off and update windows are kept trivially.
	initial o_pins = {1'b1, 4'hf, 2'h0, 13'h0000};
	// --------------------------------------------------------------
	// Pin driver
	// --------------------------------------------------------------
	// Idle lines flip every cycle so a stale value is never mistaken for
	// a held one; chip select stays high while clock enable is high.
	always @(posedge i_mclk)
	begin
		#1;
		if (pend)
		begin
			o_pins = req;
			pend = 1'b0;
		end
		else
		begin
			nx = ~o_pins;
			nx.cke = o_pins.cke;
			if (o_pins.cke)
				nx.cs_n = 1'b1;
			o_pins = nx;
		end
	end
	// One command is held for exactly one sampled edge.
	task send(input dcrc_pins_t p);
		req = p;
		pend = 1'b1;
		@(posedge i_mclk);
		@(posedge i_mclk);
		#2;
	endtask
	// idle exit interval, then one refresh
	task after_exit();
		repeat (T_XSNR) @(posedge i_mclk);
		#2;
		send({1'b1, 4'h1, 2'h0, 13'h0000});
	endtask
endmodule
`default_nettype wire

// ### dcrc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dcrc_top_tb;
	import dcrc_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	dcrc_pins_t pins;
	dcrc_cfg_t cfg = '0;
	logic [3:0] open_b;
	logic [3:0][12:0] row_b;
	dcrc_beat_t beat;
	logic sr;
	logic dll;
	logic rf;
	int bad_count = 0;
	int checked = 0;
	int seed = 17;
	int mrow[4];
	logic [3:0] mopen = 4'h0;
	always #5 i_mclk = ~i_mclk;
	dcrc_ctrl_model #(.T_XSNR(20)) i_ctl (.i_mclk(i_mclk), .o_pins(pins));
	dcrc_top i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_pins(pins),
		.i_cfg(cfg), .o_bank_open(open_b), .o_bank_row(row_b),
		.o_beat(beat), .o_self_refresh(sr), .o_dll_on(dll), .o_refresh(rf));
	task chk(string n, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task step(int n);
		repeat (n) @(posedge i_mclk);
		#2;
	endtask
	task done(string t);
		$display("test %s finished", t);
	endtask
	task summarize();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic dcrc_pins_t cm(logic [3:0] c, logic [1:0] b,
		logic [12:0] a, logic k);
		return {k, c, b, a};
	endfunction
	// Burst order: interleave xors, sequential adds inside each group of four columns.
	function automatic int cl_at(int c, int i);
		int m;
		m = cfg.bl8 ? 7 : 3;
		if (cfg.interleave)
			return (c & ~m) | ((c ^ i) & m);
		return (c & ~m) | ((c ^ i) & m & 4) | ((c + i) & 3);
	endfunction
	task banks();
		chk("open", mopen, open_b);
		for (int b = 0; b < 4; b++)
			if (mopen[b])
				chk("row", mrow[b], row_b[b]);
	endtask
	task act(int b);
		mrow[b] = $random(seed) & 16'h1fff;
		i_ctl.send(cm(4'h3, b[1:0], mrow[b][12:0], 1'b1));
		step(3);
		mopen[b] = 1'b1;
		banks();
	endtask
	task col(logic w, logic ap, int b, int c);
		int h;
		int d;
		h = cfg.bl8 ? 4 : 2;
		i_ctl.send(cm({3'h2, ~w}, b[1:0], {2'h0, ap, c[9:0]}, 1'b1));
		if (ap)
		begin
			d = cfg.al + (w ? cfg.cl - 1 + cfg.wr : 0) + h;
			step(d);
			chk("ap open", 1, open_b[b]);
			step(1);
			mopen[b] = 1'b0;
			chk("ap close", 0, open_b[b]);
		end
		else
		begin
			step(1 + cfg.al);
			for (int k = 0; k < h; k++)
			begin
				step(1);
				chk("beat", {1'b1, w, b[1:0]},
					{beat.valid, beat.write, beat.bank});
				chk("col a", cl_at(c, 2 * k), beat.col_a);
				chk("col b", cl_at(c, 2 * k + 1), beat.col_b);
			end
			step(1);
			chk("beat end", 0, beat.valid);
			banks();
		end
	endtask
	initial
	begin
		#200000;
		bad_count++;
		summarize();
	end
	initial
	begin
		int n;
		step(4);
		i_rst = 1'b0;
		step(6);
		chk("reset", 8'h02, {open_b, beat.valid, sr, dll, rf});
		done("reset");
		cfg.cl = 3'h3;
		cfg.wr = 3'h2;
		for (int b = 0; b < 4; b++)
			act(b);
		done("activate");
		// Latency is changed only between accesses, never under one.
		for (int i = 0; i < 9; i++)
		begin
			cfg.al = 3'(i % 7);
			cfg.bl8 = i[1];
			cfg.interleave = i[2];
			col(i[0], 1'b0, $random(seed) & 3, $random(seed) & 1023);
		end
		done("column");
		cfg.al = 3'h0;
		cfg.bl8 = 1'b1;
		cfg.interleave = 1'b0;
		col(1'b0, 1'b1, 0, 8);
		act(0);
		cfg.bl8 = 1'b0;
		cfg.wr = 3'h3;
		col(1'b1, 1'b1, 0, 16);
		done("auto precharge");
		i_ctl.send(cm(4'h2, 2'h0, 13'h0400, 1'b1));
		step(3);
		mopen = 4'h0;
		banks();
		act(3);
		i_ctl.send(cm(4'h1, 2'h0, 13'h0000, 1'b1));
		step(2);
		mopen = 4'h0;
		chk("refresh", 1, rf);
		banks();
		step(1);
		chk("refresh end", 0, rf);
		done("precharge and refresh");
		act(0);
		i_ctl.send(cm(4'h7, 2'h1, 13'h0555, 1'b1));
		i_ctl.send(cm(4'hb, 2'h1, 13'h0aaa, 1'b1));
		step(4);
		banks();
		i_ctl.send(cm(4'h2, 2'h0, 13'h0000, 1'b1));
		step(2);
		mopen[0] = 1'b0;
		banks();
		done("idle commands");
		i_ctl.send(cm(4'h1, 2'h0, 13'h0000, 1'b0));
		step(3);
		mopen = 4'h0;
		chk("enter", 6'h20, {sr, dll, open_b});
		n = 0;
		step(2);
		repeat (1560)
		begin
			step(1);
			if (rf === 1'b1)
				n++;
		end
		chk("self ticks", 2, n);
		i_ctl.send(cm(4'hf, 2'h0, 13'h0000, 1'b1));
		step(3);
		chk("exit", 2'h1, {sr, dll});
		i_ctl.after_exit();
		step(2);
		chk("extra refresh", 1, rf);
		act(2);
		done("self refresh");
		summarize();
	end
endmodule
`default_nettype wire
